// file: common/seq_pkg.sv
// constants and types shared by the drive main sequencer
package seq_pkg;

  typedef enum logic [2:0] {
    START_DISABLED,
    START_ENABLED,
    SWITCHED_ON,
    READY,
    ENABLED,
    FSTOP_ACTIVE,
    TRIP_ACTIVE,
    TRIPPED
  } main_state_t;

  typedef struct packed {
    logic tripped;
    logic running;
    logic jogging;
    logic stopping;
    logic contactor;
    logic sw_on_en;
    logic switched_on;
    logic ready;
    logic healthy;
  } flags_t;

  typedef struct packed {
    main_state_t st;
    logic [31:0] cnt;
    logic        trst_prev;
    logic        fs_coast;
    logic        cfg_mode;
    flags_t      fl;
    logic [31:0] rdata;
  } core_t;

  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  STAT_ADDR      = 4'h4;
  localparam int          CTRL_COAST_BIT = 0;
  localparam int          CTRL_CFG_BIT   = 1;
  localparam longint      CLK_HZ         = 200_000_000;
  localparam longint      CONT_WAIT_S    = 10;
  localparam logic [31:0] CONT_WAIT_CYC  =
    32'(CONT_WAIT_S * CLK_HZ);

  localparam flags_t FLAGS_RST = '{healthy: 1'b1, default: 1'b0};
  localparam core_t  CORE_RST  = '{
    st: START_DISABLED, cnt: 32'h0, trst_prev: 1'b0,
    fs_coast: 1'b0, cfg_mode: 1'b0, fl: FLAGS_RST,
    rdata: 32'h0};

endpackage : seq_pkg

// file: core/drive_main_sequencer_fsm.sv
// drive main sequencing state machine with a small register port
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module drive_main_sequencer_fsm #(
  parameter logic [31:0] CONT_WAIT = seq_pkg::CONT_WAIT_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cfg_restore_i,
  input  wire logic        run_i,
  input  wire logic        jog_i,
  input  wire logic        enable_i,
  input  wire logic        coast_stop_n_i,
  input  wire logic        fast_stop_n_i,
  input  wire logic        trip_i,
  input  wire logic        trip_reset_i,
  input  wire logic        contactor_closed_i,
  input  wire logic        defluxed_i,
  input  wire logic        stop_done_i,
  input  wire logic        jog_delay_done_i,
  input  wire logic        fs_timer_done_i,
  input  wire logic        zero_setpoint_i,
  input  wire logic        stack_quenched_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic [2:0]       main_state_code_o,
  output seq_pkg::flags_t  flags_o
);

  seq_pkg::core_t q_r;
  seq_pkg::core_t q_nxt;
  logic           stops_ok;
  logic           idle;
  logic           cont_timeout;

  function automatic seq_pkg::flags_t decode(
    input seq_pkg::main_state_t s,
    input seq_pkg::flags_t      prev,
    input logic                 jog_now,
    input logic                 stop_now,
    input logic                 idle_now
  );
    seq_pkg::flags_t f;
    f = '0;
    f.tripped     = (s == seq_pkg::TRIP_ACTIVE)
                  || (s == seq_pkg::TRIPPED);
    f.running     = (s == seq_pkg::ENABLED);
    f.sw_on_en    = (s != seq_pkg::START_DISABLED)
                  && (s != seq_pkg::TRIPPED);
    f.switched_on = (s >= seq_pkg::SWITCHED_ON)
                  && (s <= seq_pkg::TRIP_ACTIVE);
    f.ready       = (s >= seq_pkg::READY)
                  && (s <= seq_pkg::TRIP_ACTIVE);
    if (s == seq_pkg::START_DISABLED || s == seq_pkg::START_ENABLED)
    begin
      f.contactor = prev.contactor;
    end
    else
    begin
      f.contactor = (s != seq_pkg::TRIPPED);
    end
    f.jogging  = jog_now;
    f.stopping = (s == seq_pkg::FSTOP_ACTIVE) || stop_now;
    if (s == seq_pkg::TRIP_ACTIVE)
    begin
      f.healthy = 1'b0;
    end
    else if (s == seq_pkg::TRIPPED)
    begin
      f.healthy = prev.healthy || idle_now;
    end
    else
    begin
      f.healthy = 1'b1;
    end
    return f;
  endfunction : decode

  always_comb
  begin
    logic jog_now;
    logic stop_now;
    q_nxt        = q_r;
    jog_now      = 1'b0;
    stop_now     = 1'b0;
    idle         = !run_i && !jog_i;
    stops_ok     = coast_stop_n_i && fast_stop_n_i;
    cont_timeout = !contactor_closed_i
                && (q_r.cnt >= CONT_WAIT - 32'h1);
    q_nxt.rdata     = 32'h0;
    q_nxt.trst_prev = trip_reset_i;
    if (wr_i && addr_i == seq_pkg::CTRL_ADDR)
    begin
      q_nxt.fs_coast = wdata_i[seq_pkg::CTRL_COAST_BIT];
      q_nxt.cfg_mode = wdata_i[seq_pkg::CTRL_CFG_BIT];
    end
    if (rd_i && addr_i == seq_pkg::CTRL_ADDR)
    begin
      q_nxt.rdata = {30'h0, q_r.cfg_mode, q_r.fs_coast};
    end
    else if (rd_i && addr_i == seq_pkg::STAT_ADDR)
    begin
      q_nxt.rdata = {20'h0, q_r.fl, q_r.st};
    end
    // TRIP_ACTIVE exit tested first in every branch that has one
    case (q_r.st)
      seq_pkg::START_DISABLED:
      begin
        if (trip_i)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (idle && stops_ok)
          q_nxt.st = seq_pkg::START_ENABLED;
      end
      seq_pkg::START_ENABLED:
      begin
        if (trip_i)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (!stops_ok)
          q_nxt.st = seq_pkg::START_DISABLED;
        else if (!idle)
          q_nxt.st = seq_pkg::SWITCHED_ON;
      end
      seq_pkg::SWITCHED_ON:
      begin
        if (trip_i || cont_timeout)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (!stops_ok)
          q_nxt.st = seq_pkg::START_DISABLED;
        else if (idle)
          q_nxt.st = seq_pkg::START_ENABLED;
        else if (contactor_closed_i && defluxed_i)
          q_nxt.st = seq_pkg::READY;
      end
      seq_pkg::READY:
      begin
        if (trip_i || !contactor_closed_i)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (!stops_ok)
          q_nxt.st = seq_pkg::START_DISABLED;
        else if (idle)
          q_nxt.st = seq_pkg::START_ENABLED;
        else if (enable_i)
          q_nxt.st = seq_pkg::ENABLED;
      end
      seq_pkg::ENABLED:
      begin
        if (trip_i || !contactor_closed_i)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (!coast_stop_n_i)
          q_nxt.st = seq_pkg::START_DISABLED;
        else if (!fast_stop_n_i)
          q_nxt.st = seq_pkg::FSTOP_ACTIVE;
        else if (idle && stop_done_i)
          q_nxt.st = seq_pkg::START_ENABLED;
        else if (!enable_i)
          q_nxt.st = seq_pkg::READY;
      end
      seq_pkg::FSTOP_ACTIVE:
      begin
        if (trip_i || !contactor_closed_i)
          q_nxt.st = seq_pkg::TRIP_ACTIVE;
        else if (fs_timer_done_i || q_r.fs_coast || zero_setpoint_i)
          q_nxt.st = seq_pkg::START_DISABLED;
      end
      seq_pkg::TRIP_ACTIVE:
      begin
        if (stack_quenched_i)
          q_nxt.st = seq_pkg::TRIPPED;
      end
      seq_pkg::TRIPPED:
      begin
        if (!trip_i && trip_reset_i && !q_r.trst_prev)
          q_nxt.st = seq_pkg::START_DISABLED;
      end
      default:
      begin
        q_nxt.st = seq_pkg::START_DISABLED;
      end
    endcase
    if (cfg_restore_i || q_r.cfg_mode)
    begin
      q_nxt.st = seq_pkg::START_DISABLED;
    end
    if (q_r.st == seq_pkg::SWITCHED_ON && !contactor_closed_i
        && q_nxt.st == seq_pkg::SWITCHED_ON)
    begin
      q_nxt.cnt = q_r.cnt + 32'h1;
    end
    else
    begin
      q_nxt.cnt = 32'h0;
    end
    if (q_nxt.st == seq_pkg::ENABLED)
    begin
      if (!q_r.fl.jogging)
        jog_now = jog_i && !run_i;
      else
        jog_now = !(jog_delay_done_i || run_i);
      stop_now = idle && !stop_done_i;
    end
    q_nxt.fl = decode(q_nxt.st, q_r.fl, jog_now, stop_now, idle);
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      q_r <= seq_pkg::CORE_RST;
    else if (ce_i)
      q_r <= q_nxt;
  end

  assign rdata_o           = q_r.rdata;
  assign main_state_code_o = q_r.st;
  assign flags_o           = q_r.fl;

  chk_code_tripped_flag: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.tripped == (main_state_code_o >= 3'h6))
    else $error("tripped flag disagrees with state");

  chk_running_enabled: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.running == (main_state_code_o == 3'h4))
    else $error("running flag disagrees with state");

  chk_ready_window: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.ready |-> (main_state_code_o inside {[3'h3:3'h6]}))
    else $error("ready flag outside its states");

  chk_contactor_hold: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && main_state_code_o <= 3'h1)
    ##1 (main_state_code_o <= 3'h1)
    |-> flags_o.contactor == $past(flags_o.contactor))
    else $error("contactor changed in a start state");

  chk_trip_no_health: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (main_state_code_o == 3'h6) |-> !flags_o.healthy)
    else $error("healthy high in trip-active");

  chk_ready_trip_fast: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::READY && !contactor_closed_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h6))
    else $error("ready did not trip on open contactor");

  chk_trip_reset_edge: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::TRIPPED && !trip_i
     && trip_reset_i && !q_r.trst_prev)
    |=> (main_state_code_o == 3'h0))
    else $error("trip reset edge did not clear trip");

  chk_tripped_stays: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (q_r.st == seq_pkg::TRIPPED && trip_i && !cfg_restore_i
     && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h7))
    else $error("tripped left while trip present");

  chk_fstop_stopping: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (main_state_code_o == 3'h5) |-> flags_o.stopping)
    else $error("stopping low in fast-stop state");

  chk_sw_on_en_map: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.sw_on_en == !(main_state_code_o inside {3'h0, 3'h7}))
    else $error("switch-on-enable disagrees with state");

  chk_switched_on_map: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.switched_on == (main_state_code_o inside {[3'h2:3'h6]}))
    else $error("switched-on disagrees with state");

  chk_contactor_on_map: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (main_state_code_o inside {[3'h2:3'h6]}) |-> flags_o.contactor)
    else $error("contactor low in an energised state");

  chk_jog_only_enabled: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.jogging |-> (main_state_code_o == 3'h4))
    else $error("jogging outside enabled");

  chk_stop_state_set: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flags_o.stopping |-> (main_state_code_o inside {3'h4, 3'h5}))
    else $error("stopping outside enabled or fast-stop");

  chk_healthy_normal: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (main_state_code_o <= 3'h5) |-> flags_o.healthy)
    else $error("healthy low outside trip states");

  chk_trip_from_start: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && main_state_code_o <= 3'h1 && trip_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h6))
    else $error("start state did not trip");

  chk_stop_to_disabled: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && !stops_ok && !trip_i && !cfg_restore_i && !q_r.cfg_mode
     && (q_r.st == seq_pkg::START_ENABLED
         || (q_r.st == seq_pkg::SWITCHED_ON && !cont_timeout)
         || (q_r.st == seq_pkg::READY && contactor_closed_i)))
    |=> (main_state_code_o == 3'h0))
    else $error("stop input did not disable start");

  chk_idle_start_en: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::START_DISABLED && !trip_i && idle
     && stops_ok && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h1))
    else $error("idle start-disabled did not enable start");

  chk_enabled_fstop: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::ENABLED && !trip_i && !fast_stop_n_i
     && contactor_closed_i && coast_stop_n_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h5))
    else $error("enabled did not enter fast-stop");

  chk_fstop_exit: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::FSTOP_ACTIVE && !trip_i
     && contactor_closed_i && !cfg_restore_i && !q_r.cfg_mode
     && (fs_timer_done_i || q_r.fs_coast || zero_setpoint_i))
    |=> (main_state_code_o == 3'h0))
    else $error("fast-stop did not end");

  chk_quench_tripped: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::TRIP_ACTIVE && stack_quenched_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h7))
    else $error("quenched stack did not reach tripped");

  chk_cfg_forces: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && (cfg_restore_i || q_r.cfg_mode))
    |=> (main_state_code_o == 3'h0))
    else $error("configuration did not force start-disabled");

  chk_switched_ready: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::SWITCHED_ON && !trip_i && !cont_timeout
     && stops_ok && !idle && contactor_closed_i && defluxed_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h3))
    else $error("switched-on did not reach ready");

  chk_ready_enable: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::READY && !trip_i && contactor_closed_i
     && stops_ok && !idle && enable_i
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h4))
    else $error("ready did not enable");

  chk_cont_timeout: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::SWITCHED_ON && cont_timeout
     && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h6))
    else $error("open contactor wait did not trip");

  chk_start_switch: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (ce_i && q_r.st == seq_pkg::START_ENABLED && !trip_i && stops_ok
     && !idle && !cfg_restore_i && !q_r.cfg_mode)
    |=> (main_state_code_o == 3'h2))
    else $error("start-enabled did not switch on");

endmodule : drive_main_sequencer_fsm
`default_nettype wire

// file: testbench/stack_feedback_model.sv
// power stage feedback model facing the drive sequencer
`timescale 1ns/100ps
`default_nettype none
module stack_feedback_model #(
  parameter logic [3:0] DLY = 4'h3
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic contactor_cmd_i,
  input  wire logic tripped_i,
  input  wire logic force_open_i,
  output logic      contactor_closed_o,
  output logic      defluxed_o,
  output logic      stack_quenched_o
);
  logic [3:0] c_cnt_r;
  logic [3:0] q_cnt_r;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      c_cnt_r <= 4'h0;
      q_cnt_r <= 4'h0;
    end
    else
    begin
      if (contactor_cmd_i && !force_open_i)
        c_cnt_r <= (c_cnt_r == DLY) ? c_cnt_r : c_cnt_r + 4'h1;
      else
        c_cnt_r <= 4'h0;
      if (tripped_i)
        q_cnt_r <= (q_cnt_r == DLY) ? q_cnt_r : q_cnt_r + 4'h1;
      else
        q_cnt_r <= 4'h0;
    end
  end

  // closes, defluxes and quenches a few cycles late
  assign contactor_closed_o = (c_cnt_r == DLY);
  assign defluxed_o         = contactor_closed_o;
  assign stack_quenched_o   = (q_cnt_r == DLY);
endmodule : stack_feedback_model
`default_nettype wire

// file: testbench/drive_main_sequencer_fsm_tb.sv
// self-checking bench for the drive main sequencer
`timescale 1ns/100ps
`default_nettype none
module drive_main_sequencer_fsm_tb;
  logic            clock_i, rst_i, run_i, jog_i, enable_i, coast_n, fast_n;
  logic            trip_i, trip_reset_i, zero_sp, open_c, wr_i, rd_i;
  logic            cc, dfx, sq, cfg_r, stop_d;
  logic [3:0]      addr_i;
  logic [31:0]     wdata_i, rdata;
  logic [2:0]      st;
  seq_pkg::flags_t fl;
  int              n_errors, check_count;

  drive_main_sequencer_fsm #(.CONT_WAIT(32'h14)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .cfg_restore_i(cfg_r),
    .run_i(run_i), .jog_i(jog_i), .enable_i(enable_i),
    .coast_stop_n_i(coast_n), .fast_stop_n_i(fast_n), .trip_i(trip_i),
    .trip_reset_i(trip_reset_i), .contactor_closed_i(cc),
    .defluxed_i(dfx), .stop_done_i(stop_d), .jog_delay_done_i(1'b0),
    .fs_timer_done_i(1'b0), .zero_setpoint_i(zero_sp),
    .stack_quenched_i(sq), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .main_state_code_o(st), .flags_o(fl));

  stack_feedback_model fb (
    .clock_i(clock_i), .rst_i(rst_i), .contactor_cmd_i(fl.contactor),
    .tripped_i(fl.tripped), .force_open_i(open_c),
    .contactor_closed_o(cc), .defluxed_o(dfx), .stack_quenched_o(sq));

  task automatic complete_run;
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // bounded wait for a state, then compare state and flags
  task automatic go(input logic [2:0] s, input logic [8:0] f);
    int i;
    i = 0;
    while (st !== s && i < 60)
    begin
      @(posedge clock_i);
      #1;
      i++;
    end
    check({29'h0, st}, {29'h0, s});
    check({23'h0, fl}, {23'h0, f});
    if (i == 60)
      complete_run();
  endtask : go

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
  endtask : bus

  task automatic clear_trip;
    @(posedge clock_i);
    trip_reset_i <= 1'b1;
    go(3'h0, 9'h001);
    @(posedge clock_i);
    trip_reset_i <= 1'b0;
  endtask : clear_trip

  task automatic t_walk;
    go(3'h0, 9'h001);
    go(3'h1, 9'h009);
    @(posedge clock_i);
    run_i <= 1'b1;
    go(3'h2, 9'h01D);
    go(3'h3, 9'h01F);
    @(posedge clock_i);
    enable_i <= 1'b1;
    go(3'h4, 9'h09F);
    bus(1'b0, seq_pkg::STAT_ADDR, 32'h0);
    check(rdata, {20'h0, 9'h09F, 3'h4});
    bus(1'b0, 4'h8, 32'h0);
    check(rdata, 32'h0);
    @(posedge clock_i);
    enable_i <= 1'b0;
    go(3'h3, 9'h01F);
    @(posedge clock_i);
    enable_i <= 1'b1;
    go(3'h4, 9'h09F);
    @(posedge clock_i);
    fast_n <= 1'b0;
    go(3'h5, 9'h03F);
    @(posedge clock_i);
    zero_sp <= 1'b1;
    go(3'h0, 9'h011);
    @(posedge clock_i);
    fast_n  <= 1'b1;
    zero_sp <= 1'b0;
    run_i   <= 1'b0;
    go(3'h1, 9'h019);
    bus(1'b1, seq_pkg::CTRL_ADDR, 32'h2);
    go(3'h0, 9'h011);
    repeat (3) @(posedge clock_i);
    #1;
    check({29'h0, st}, 32'h0);
    bus(1'b1, seq_pkg::CTRL_ADDR, 32'h0);
    go(3'h1, 9'h019);
  endtask : t_walk

  task automatic t_trip;
    @(posedge clock_i);
    trip_i  <= 1'b1;
    coast_n <= 1'b0;
    jog_i   <= 1'b1;
    go(3'h6, 9'h11E);
    go(3'h7, 9'h100);
    @(posedge clock_i);
    jog_i        <= 1'b0;
    trip_reset_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    check({29'h0, st}, 32'h7);
    check({23'h0, fl}, 32'h101);
    @(posedge clock_i);
    trip_i       <= 1'b0;
    coast_n      <= 1'b1;
    trip_reset_i <= 1'b0;
    clear_trip();
  endtask : t_trip

  task automatic t_cont;
    @(posedge clock_i);
    open_c <= 1'b1;
    run_i  <= 1'b1;
    go(3'h2, 9'h01D);
    @(posedge clock_i);
    coast_n <= 1'b0;
    go(3'h0, 9'h011);
    @(posedge clock_i);
    coast_n <= 1'b1;
    run_i   <= 1'b0;
    go(3'h1, 9'h019);
    @(posedge clock_i);
    run_i <= 1'b1;
    go(3'h2, 9'h01D);
    @(posedge clock_i);
    run_i <= 1'b0;
    go(3'h1, 9'h019);
    @(posedge clock_i);
    run_i <= 1'b1;
    go(3'h2, 9'h01D);
    repeat (12) @(posedge clock_i);
    #1;
    check({29'h0, st}, 32'h2);
    go(3'h6, 9'h11E);
    go(3'h7, 9'h100);
    @(posedge clock_i);
    open_c <= 1'b0;
    run_i  <= 1'b0;
    clear_trip();
  endtask : t_cont

  task automatic t_stop;
    @(posedge clock_i);
    stop_d <= 1'b0;
    run_i  <= 1'b1;
    go(3'h2, 9'h01D);
    go(3'h3, 9'h01F);
    @(posedge clock_i);
    enable_i <= 1'b1;
    go(3'h4, 9'h09F);
    @(posedge clock_i);
    run_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check({29'h0, st}, 32'h4);
    check({23'h0, fl}, 32'h0BF);
    @(posedge clock_i);
    stop_d <= 1'b1;
    go(3'h1, 9'h019);
    @(posedge clock_i);
    jog_i <= 1'b1;
    go(3'h4, 9'h0DF);
    @(posedge clock_i);
    jog_i <= 1'b0;
    go(3'h1, 9'h019);
    @(posedge clock_i);
    cfg_r    <= 1'b1;
    enable_i <= 1'b0;
    go(3'h0, 9'h011);
    @(posedge clock_i);
    cfg_r <= 1'b0;
    go(3'h1, 9'h019);
  endtask : t_stop

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  initial
  begin
    {run_i, jog_i, enable_i, trip_i, trip_reset_i, zero_sp} = 6'h00;
    {open_c, wr_i, rd_i} = 3'h0;
    {cfg_r, stop_d} = 2'h1;
    {coast_n, fast_n} = 2'h3;
    addr_i      = 4'h0;
    wdata_i     = 32'h0;
    n_errors    = 0;
    check_count = 0;
    rst_i       = 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    t_walk();
    t_trip();
    t_cont();
    t_stop();
    complete_run();
  end
endmodule : drive_main_sequencer_fsm_tb
`default_nettype wire
